/* core/fes_pkg.sv */
// Package with the register map, field layout, reset values and shared helpers.
package fes_pkg;
  localparam int NPORT = 16;
  localparam int ADDR_W = 20;
  // Byte addresses of the registers.
  localparam logic [19:0] ADDR_TIMEOUT_STATUS = 20'h1aa04;
  localparam logic [19:0] ADDR_LATENCY_ERROR = 20'h1aa08;
  localparam logic [19:0] ADDR_CONTROL = 20'h1aa10;
  localparam logic [19:0] ADDR_GLOBAL_STATUS = 20'h1aa14;
  localparam logic [19:0] ADDR_INT_STATUS = 20'h1aa18;
  localparam logic [19:0] ADDR_INT_MASK = 20'h1aa1c;
  // Control register field positions.
  localparam int CTRL_PERIOD_LSB = 0;
  localparam int CTRL_TIMER_EN_BIT = 16;
  localparam int CTRL_IRQ_EN_BIT = 17;
  localparam int CTRL_AUTO_EXCL_BIT = 18;
  // Global status and event bit positions.
  localparam int GLOB_TIMEOUT_BIT = 24;
  localparam int GLOB_LATENCY_BIT = 17;
  // Values after reset.
  localparam logic [15:0] PERIOD_RESET = 16'h0200;
  localparam logic TIMER_EN_RESET = 1'b1;
  localparam logic IRQ_EN_RESET = 1'b0;
  localparam logic AUTO_EXCL_RESET = 1'b0;
  localparam logic [31:0] INT_MASK_RESET = 32'h01020000;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  // One timeout period unit is two to the fifteenth clock cycles.
  localparam int TICK_CYCLES = 32768;

  // Control settings that steer the timers and the exclusion.
  typedef struct packed {
    logic autoExclude;
    logic irqEnable;
    logic timerEnable;
    logic [15:0] period;
  } fes_ctrl_s;

  // Places sixteen port flags in a status word, port p at bit p.
  function automatic logic [31:0] flagWord(input logic [NPORT-1:0] f);
    return {16'h0000, f};
  endfunction : flagWord

  // Expands Avalon byte enables to a bit mask.
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : laneMask
endpackage : fes_pkg

/* core/fes_sticky_flags.sv */
// Sixteen sticky flags, set by events and cleared by writing one.
`timescale 1ns/100ps
`default_nettype none
module fes_sticky_flags (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Set events and clear strobes.
  input wire logic [fes_pkg::NPORT-1:0] setPulse,
  input wire logic [fes_pkg::NPORT-1:0] clearBits,
  // Flag state.
  output logic [fes_pkg::NPORT-1:0] flags
);
  import fes_pkg::*;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clearBits) | setPulse;
    end
  end
endmodule : fes_sticky_flags
`default_nettype wire

/* core/fes_ack_timer.sv */
// Per-port acknowledge wait timers that flag a transaction error.
`timescale 1ns/100ps
`default_nettype none
module fes_ack_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Period unit enable and settings.
  input wire logic tick,
  input wire logic timerEnable,
  input wire logic [15:0] period,
  // Ports with a request waiting for its acknowledge.
  input wire logic [fes_pkg::NPORT-1:0] ackWaiting,
  // One-cycle transaction error pulses.
  output logic [fes_pkg::NPORT-1:0] timeoutPulse
);
  import fes_pkg::*;

  logic [15:0] unitCount [NPORT];
  logic [NPORT-1:0] fired;
  logic timerOn;

  // A zero period stops the timers as if they were disabled.
  assign timerOn = timerEnable && (period != 16'h0000);

  // Counts period units while waiting; fires once when the wait runs past the period.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < NPORT; p++) begin
        unitCount[p] <= 16'h0000;
      end
      fired <= '0;
      timeoutPulse <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        timeoutPulse[p] <= 1'b0;
        if (!ackWaiting[p] || !timerOn) begin
          unitCount[p] <= 16'h0000;
          fired[p] <= 1'b0;
        end else if (tick && !fired[p]) begin
          if (unitCount[p] >= period) begin
            timeoutPulse[p] <= 1'b1;
            fired[p] <= 1'b1;
          end else begin
            unitCount[p] <= unitCount[p] + 16'h0001;
          end
        end
      end
    end
  end
endmodule : fes_ack_timer
`default_nettype wire

/* core/fes_error_status.sv */
// Fabric error status: timeout and latency flags, control, interrupts, Avalon slave.
//
// Function
// - Sticky timeout flag per port, set on error.
// - Timeout flags: port 15 bit 16, port 0 bit 31; the code puts port p at bit p.
// - Writing one clears a timeout flag.
// - Interrupt request is OR of timeout flags.
// - Clearing last flag drops the interrupt request.
// - Sticky latency flag per port, set on expiry.
// - Latency flags same layout, write one clears.
// - Auto exclusion blocks multicast to flagged ports.
// - Any latency flag set raises global exception.
// - Timeout after period times 2^15; zero disables.
// - Timeout interrupt only when its enable is set.
// - Global status: timeout bit 7, latency bit 14; the code uses bits 24 and 17.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module fes_error_status #(
  parameter int TICK_LEN = fes_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [fes_pkg::ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Fabric events.
  input wire logic [fes_pkg::NPORT-1:0] ackWaiting,
  input wire logic [fes_pkg::NPORT-1:0] latencyExpired,
  // Fabric outputs.
  output logic fabricIrqReq,
  output logic [fes_pkg::NPORT-1:0] multicastExclude,
  output logic irq
);
  import fes_pkg::*;

  localparam int TICK_W = $clog2(TICK_LEN + 1);

  logic busAck_reg;
  logic writeFire;
  logic readTake;
  logic [31:0] wrBits;
  logic [TICK_W-1:0] tickCount_reg;
  logic tick_reg;
  fes_ctrl_s ctrl_reg;
  logic [31:0] intStatus_reg;
  logic [31:0] intMask_reg;
  logic [31:0] intSet;
  logic [NPORT-1:0] timeoutPulse;
  logic [NPORT-1:0] timeoutFlags;
  logic [NPORT-1:0] latencyFlags;
  logic [NPORT-1:0] timeoutClear;
  logic [NPORT-1:0] latencyClear;
  logic [31:0] globalStatus;
  logic [31:0] readMux;

  // One wait state: the request is answered on its second cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busAck_reg <= 1'b0;
    end else begin
      busAck_reg <= (avsRead || avsWrite) && !busAck_reg;
    end
  end

  // Handshake and write strobes.
  assign avsWaitRequest = (avsRead || avsWrite) && !busAck_reg;
  assign writeFire = avsWrite && busAck_reg;
  assign readTake = avsRead && !busAck_reg;
  assign wrBits = avsWriteData & laneMask(avsByteEnable);

  // Only ones in the low half clear flags; zeros and upper bits do nothing.
  assign timeoutClear = (writeFire && avsAddress == ADDR_TIMEOUT_STATUS) ?
      wrBits[NPORT-1:0] : '0;
  assign latencyClear = (writeFire && avsAddress == ADDR_LATENCY_ERROR) ?
      wrBits[NPORT-1:0] : '0;

  // Divider giving one enable pulse per period unit.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tickCount_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tickCount_reg == TICK_W'(TICK_LEN - 1)) begin
      tickCount_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tickCount_reg <= tickCount_reg + TICK_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // Control register, written by software.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg.period <= PERIOD_RESET;
      ctrl_reg.timerEnable <= TIMER_EN_RESET;
      ctrl_reg.irqEnable <= IRQ_EN_RESET;
      ctrl_reg.autoExclude <= AUTO_EXCL_RESET;
    end else if (writeFire && avsAddress == ADDR_CONTROL) begin
      if (avsByteEnable[0]) begin
        ctrl_reg.period[7:0] <= avsWriteData[CTRL_PERIOD_LSB +: 8];
      end
      if (avsByteEnable[1]) begin
        ctrl_reg.period[15:8] <= avsWriteData[CTRL_PERIOD_LSB + 8 +: 8];
      end
      if (avsByteEnable[2]) begin
        ctrl_reg.timerEnable <= avsWriteData[CTRL_TIMER_EN_BIT];
        ctrl_reg.irqEnable <= avsWriteData[CTRL_IRQ_EN_BIT];
        ctrl_reg.autoExclude <= avsWriteData[CTRL_AUTO_EXCL_BIT];
      end
    end
  end

  // Acknowledge wait timers.
  fes_ack_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(tick_reg),
    .timerEnable(ctrl_reg.timerEnable),
    .period(ctrl_reg.period),
    .ackWaiting(ackWaiting),
    .timeoutPulse(timeoutPulse)
  );

  // Timeout flags, one per port.
  fes_sticky_flags u_timeoutFlags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .setPulse(timeoutPulse),
    .clearBits(timeoutClear),
    .flags(timeoutFlags)
  );

  // Latency expired flags, one per port.
  fes_sticky_flags u_latencyFlags (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .setPulse(latencyExpired),
    .clearBits(latencyClear),
    .flags(latencyFlags)
  );

  // Fabric request follows any timeout flag and falls with the last clear.
  assign fabricIrqReq = |timeoutFlags;

  // Flagged ports lose multicast delivery while exclusion is on.
  assign multicastExclude = ctrl_reg.autoExclude ? latencyFlags : '0;

  // Global summary word.
  always_comb begin
    globalStatus = 32'h00000000;
    globalStatus[GLOB_TIMEOUT_BIT] = fabricIrqReq;
    globalStatus[GLOB_LATENCY_BIT] = |latencyFlags;
  end

  // Interrupt events: timeouts only when enabled, latency always.
  always_comb begin
    intSet = 32'h00000000;
    intSet[GLOB_TIMEOUT_BIT] = ctrl_reg.irqEnable && (|timeoutPulse);
    intSet[GLOB_LATENCY_BIT] = |latencyExpired;
  end

  // Sticky event status, cleared by writing one; a new event wins.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intStatus_reg <= STATUS_RESET;
    end else if (writeFire && avsAddress == ADDR_INT_STATUS) begin
      intStatus_reg <= (intStatus_reg & ~wrBits) | intSet;
    end else begin
      intStatus_reg <= intStatus_reg | intSet;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intMask_reg <= INT_MASK_RESET;
    end else if (writeFire && avsAddress == ADDR_INT_MASK) begin
      intMask_reg <= (intMask_reg & ~laneMask(avsByteEnable)) | wrBits;
    end
  end

  // Level interrupt while any unmasked event bit stands.
  assign irq = |(intStatus_reg & intMask_reg);

  // Read decode; unmapped addresses read zero.
  always_comb begin
    unique case (avsAddress)
      ADDR_TIMEOUT_STATUS: readMux = flagWord(timeoutFlags);
      ADDR_LATENCY_ERROR: readMux = flagWord(latencyFlags);
      ADDR_CONTROL: readMux = {13'h0000, ctrl_reg};
      ADDR_GLOBAL_STATUS: readMux = globalStatus;
      ADDR_INT_STATUS: readMux = intStatus_reg;
      ADDR_INT_MASK: readMux = intMask_reg;
      default: readMux = 32'h00000000;
    endcase
  end

  // Read data is captured in the first cycle and stands at the answer edge.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avsReadData <= 32'h00000000;
    end else if (readTake) begin
      avsReadData <= readMux;
    end
  end

  // Timeout events always land in their flags.
  property p_timeout_sets;
    @(posedge sys_clk) disable iff (!rstn)
    (timeoutPulse != '0) |=> ((timeoutFlags & $past(timeoutPulse)) == $past(timeoutPulse));
  endproperty
  a_timeout_sets: assert property (p_timeout_sets)
    else $error("timeout event did not set its flag");

  // A one written without a new event clears the flag.
  property p_timeout_clear;
    @(posedge sys_clk) disable iff (!rstn)
    ((timeoutClear & ~timeoutPulse) != '0) |=>
      ((timeoutFlags & $past(timeoutClear) & ~$past(timeoutPulse)) == '0);
  endproperty
  a_timeout_clear: assert property (p_timeout_clear)
    else $error("write of one did not clear timeout flag");

  // Set and clear together leave the flag set.
  property p_set_wins;
    @(posedge sys_clk) disable iff (!rstn)
    ((timeoutClear & timeoutPulse) != '0) |=>
      ((timeoutFlags & $past(timeoutClear) & $past(timeoutPulse)) ==
       ($past(timeoutClear) & $past(timeoutPulse)));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous timeout event");

  // Clearing every set flag with no new event drops the request.
  property p_irq_drops;
    @(posedge sys_clk) disable iff (!rstn)
    (fabricIrqReq && timeoutPulse == '0 && (timeoutFlags & ~timeoutClear) == '0)
      |=> !fabricIrqReq;
  endproperty
  a_irq_drops: assert property (p_irq_drops)
    else $error("interrupt request stayed after last clear");

  // Timeout status reads back with a zero upper half.
  property p_timeout_read;
    @(posedge sys_clk) disable iff (!rstn)
    (avsRead && !avsWaitRequest && avsAddress == ADDR_TIMEOUT_STATUS) |->
      (avsReadData == {16'h0000, $past(timeoutFlags)});
  endproperty
  a_timeout_read: assert property (p_timeout_read)
    else $error("timeout status read returned wrong word");

  // Latency expiry sets its flag and the latency event status bit.
  property p_latency_sets;
    @(posedge sys_clk) disable iff (!rstn)
    (latencyExpired != '0) |=> (((latencyFlags & $past(latencyExpired)) ==
      $past(latencyExpired)) && intStatus_reg[GLOB_LATENCY_BIT]);
  endproperty
  a_latency_sets: assert property (p_latency_sets)
    else $error("latency expiry lost");

  // Exclusion follows a latency expiry when enabled.
  property p_exclude;
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl_reg.autoExclude && latencyExpired != '0 && !writeFire) |=>
      ((multicastExclude & $past(latencyExpired)) == $past(latencyExpired));
  endproperty
  a_exclude: assert property (p_exclude)
    else $error("expired port not excluded from multicast");

  // No timeout while the period is zero.
  property p_zero_period;
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl_reg.period == 16'h0000) [*2] |-> (timeoutPulse == '0);
  endproperty
  a_zero_period: assert property (p_zero_period)
    else $error("timeout fired with zero period");

  // A disabled timeout interrupt never raises its event bit.
  property p_irq_enable;
    @(posedge sys_clk) disable iff (!rstn)
    (!ctrl_reg.irqEnable && !intStatus_reg[GLOB_TIMEOUT_BIT]) |=>
      !intStatus_reg[GLOB_TIMEOUT_BIT];
  endproperty
  a_irq_enable: assert property (p_irq_enable)
    else $error("timeout event raised with interrupt disabled");

  // Global summary reads the flag groups.
  property p_global_read;
    @(posedge sys_clk) disable iff (!rstn)
    (avsRead && !avsWaitRequest && avsAddress == ADDR_GLOBAL_STATUS) |->
      (avsReadData[GLOB_TIMEOUT_BIT] == ($past(timeoutFlags) != '0) &&
       avsReadData[GLOB_LATENCY_BIT] == ($past(latencyFlags) != '0));
  endproperty
  a_global_read: assert property (p_global_read)
    else $error("global summary does not match flags");

  // A latency expiry in the cycle of its clearing write keeps the flag.
  property p_latency_set_wins;
    @(posedge sys_clk) disable iff (!rstn)
    ((latencyClear & latencyExpired) != '0) |=>
      ((latencyFlags & $past(latencyClear) & $past(latencyExpired)) ==
       ($past(latencyClear) & $past(latencyExpired)));
  endproperty
  a_latency_set_wins: assert property (p_latency_set_wins)
    else $error("clear beat a simultaneous latency expiry");
endmodule : fes_error_status
`default_nettype wire

/* bench/fes_error_status_bench.sv */
// Self-checking bench for the fabric error status block over its Avalon-MM slave.
`timescale 1ns/100ps
`default_nettype none
module fes_error_status_bench;
  import fes_pkg::*;
  localparam int TL = 4;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = '0;
  logic [3:0] avsByteEnable = 4'h0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic [NPORT-1:0] ackWaiting = '0;
  logic [NPORT-1:0] latencyExpired = '0;
  logic fabricIrqReq;
  logic [NPORT-1:0] multicastExclude;
  logic irq;
  logic [31:0] rd;
  int failCount = 0;
  int nTests = 0;

  // The clock toggles every 50 ns, half of its 100 ns period.
  always #50 sys_clk = ~sys_clk;

  // Device under test with a short period unit.
  fes_error_status #(.TICK_LEN(TL)) i_fes_error_status (
    .sys_clk(sys_clk), .rstn(rstn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .ackWaiting(ackWaiting), .latencyExpired(latencyExpired),
    .fabricIrqReq(fabricIrqReq), .multicastExclude(multicastExclude), .irq(irq)
  );

  // Compares one value and counts the outcome.
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("Checks made %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // One Avalon transfer; the request is held until waitrequest is sampled low at a rising edge.
  task bus(input logic wr, input logic [19:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    avsByteEnable <= 4'hf;
    n = 1;
    @(posedge sys_clk);
    while (avsWaitRequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    // Read data is taken at the very edge where waitrequest is seen low.
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    check("answer edges", n, 32'd2);
  endtask : bus

  // Reads a register and compares it with the expected word.
  task rdchk(input string what, input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask : rdchk

  // Register values after reset and unmapped addresses.
  task t_reset_map;
    rdchk("timeout status reset", ADDR_TIMEOUT_STATUS, STATUS_RESET);
    rdchk("latency reset", ADDR_LATENCY_ERROR, STATUS_RESET);
    rdchk("control reset", ADDR_CONTROL,
          {13'h0, AUTO_EXCL_RESET, IRQ_EN_RESET, TIMER_EN_RESET, PERIOD_RESET});
    rdchk("mask reset", ADDR_INT_MASK, INT_MASK_RESET);
    rdchk("global reset", ADDR_GLOBAL_STATUS, 32'h00000000);
    bus(1'b1, 20'h1aa20, 32'hffffffff, rd);
    rdchk("unmapped read", 20'h1aa20, 32'h00000000);
    check("irq after reset", {31'h0, irq}, 32'h0);
  endtask : t_reset_map

  // Latency flags, exclusion, global exception, mask and set priority.
  task t_latency;
    @(posedge sys_clk);
    latencyExpired <= 16'h8001;
    @(posedge sys_clk);
    latencyExpired <= 16'h0000;
    rdchk("latency flags", ADDR_LATENCY_ERROR, 32'h00008001);
    check("no exclusion when off", {16'h0, multicastExclude}, 32'h0);
    check("latency not in fabric irq", {31'h0, fabricIrqReq}, 32'h0);
    bus(1'b1, ADDR_CONTROL, 32'h00050200, rd);
    @(negedge sys_clk);
    check("exclusion", {16'h0, multicastExclude}, 32'h00008001);
    rdchk("global latency", ADDR_GLOBAL_STATUS, 32'h1 << GLOB_LATENCY_BIT);
    rdchk("event latency", ADDR_INT_STATUS, 32'h1 << GLOB_LATENCY_BIT);
    check("irq latency", {31'h0, irq}, 32'h1);
    bus(1'b1, ADDR_INT_MASK, 32'h0, rd);
    @(negedge sys_clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_INT_MASK, INT_MASK_RESET, rd);
    bus(1'b1, ADDR_LATENCY_ERROR, 32'h00000000, rd);
    rdchk("write zero keeps", ADDR_LATENCY_ERROR, 32'h00008001);
    bus(1'b1, ADDR_LATENCY_ERROR, 32'hffff0001, rd);
    rdchk("clear port 0", ADDR_LATENCY_ERROR, 32'h00008000);
    @(posedge sys_clk);
    latencyExpired <= 16'h0020;
    bus(1'b1, ADDR_LATENCY_ERROR, 32'h0000ffff, rd);
    latencyExpired <= 16'h0000;
    rdchk("set beats clear", ADDR_LATENCY_ERROR, 32'h00000020);
    bus(1'b1, ADDR_LATENCY_ERROR, 32'h00000020, rd);
    rdchk("latency cleared", ADDR_LATENCY_ERROR, 32'h00000000);
    @(negedge sys_clk);
    check("exclusion cleared", {16'h0, multicastExclude}, 32'h0);
    bus(1'b1, ADDR_INT_STATUS, 32'h1 << GLOB_LATENCY_BIT, rd);
    @(negedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_latency

  // Acknowledge timeout on one port with the interrupt enable on or off.
  task t_timeout(input logic en, input int port);
    int n;
    logic [31:0] flag;
    flag = 32'h1 << port;
    bus(1'b1, ADDR_CONTROL, {14'h0, en, 1'b1, 16'h0001}, rd);
    @(posedge sys_clk);
    ackWaiting <= flag[15:0];
    n = 0;
    while (fabricIrqReq !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check("wait length in range", {31'h0, n >= TL + 1 && n <= 2 * TL + 3}, 32'h1);
    @(posedge sys_clk);
    ackWaiting <= 16'h0000;
    rdchk("timeout flag", ADDR_TIMEOUT_STATUS, flag);
    rdchk("global timeout", ADDR_GLOBAL_STATUS, 32'h1 << GLOB_TIMEOUT_BIT);
    rdchk("event gated", ADDR_INT_STATUS, {7'h0, en, 24'h0});
    check("irq gated", {31'h0, irq}, {31'h0, en});
    bus(1'b1, ADDR_TIMEOUT_STATUS, 32'h0, rd);
    @(negedge sys_clk);
    check("zero write keeps irq", {31'h0, fabricIrqReq}, 32'h1);
    bus(1'b1, ADDR_TIMEOUT_STATUS, flag, rd);
    @(negedge sys_clk);
    check("fabric irq dropped", {31'h0, fabricIrqReq}, 32'h0);
    rdchk("timeout cleared", ADDR_TIMEOUT_STATUS, 32'h0);
    bus(1'b1, ADDR_INT_STATUS, 32'h1 << GLOB_TIMEOUT_BIT, rd);
  endtask : t_timeout

  // Two ports time out; fabricIrqReq stays until the last one is cleared, period zero disables.
  task t_two_ports;
    bus(1'b1, ADDR_CONTROL, 32'h00010001, rd);
    @(posedge sys_clk);
    ackWaiting <= 16'h8001;
    repeat (3 * TL + 4) @(posedge sys_clk);
    ackWaiting <= 16'h0000;
    rdchk("two flags", ADDR_TIMEOUT_STATUS, 32'h00008001);
    bus(1'b1, ADDR_TIMEOUT_STATUS, 32'h00008000, rd);
    @(negedge sys_clk);
    check("one flag left", {31'h0, fabricIrqReq}, 32'h1);
    rdchk("port 15 cleared", ADDR_TIMEOUT_STATUS, 32'h00000001);
    bus(1'b1, ADDR_TIMEOUT_STATUS, 32'h00000001, rd);
    @(negedge sys_clk);
    check("last flag cleared", {31'h0, fabricIrqReq}, 32'h0);
    bus(1'b1, ADDR_CONTROL, 32'h00010000, rd);
    @(posedge sys_clk);
    ackWaiting <= 16'hffff;
    repeat (6 * TL) @(posedge sys_clk);
    ackWaiting <= 16'h0000;
    rdchk("period zero idle", ADDR_TIMEOUT_STATUS, 32'h0);
    check("no fabric irq", {31'h0, fabricIrqReq}, 32'h0);
    bus(1'b1, ADDR_CONTROL, 32'h00000001, rd);
    @(posedge sys_clk);
    ackWaiting <= 16'hffff;
    repeat (6 * TL) @(posedge sys_clk);
    ackWaiting <= 16'h0000;
    rdchk("timer off idle", ADDR_TIMEOUT_STATUS, 32'h0);
  endtask : t_two_ports

  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset_map();
    t_latency();
    t_timeout(1'b1, 3);
    t_timeout(1'b0, 12);
    t_two_ports();
    end_sim();
  end

  // Watchdog that ends a hung run.
  initial begin
    #(100 * 20000);
    failCount++;
    $display("Watchdog expired");
    end_sim();
  end
endmodule : fes_error_status_bench
`default_nettype wire
